// file: core/rdseq_pkg.sv
package rdseq_pkg;
    localparam int NUM_RAILS = 4;
    localparam int NUM_PINS = 4;
    localparam int CLK_MHZ = 100;
    // soft-off timing defaults
    localparam int SOFT_DELAY_US = 1000;
    localparam int SOFT_RAMP_US = 4500;
    localparam int SOFT_DELAY_CYC = SOFT_DELAY_US * CLK_MHZ;
    localparam int SOFT_RAMP_CYC = SOFT_RAMP_US * CLK_MHZ;
    // register offsets
    localparam logic [7:0] OFS_PIN_DIR = 8'h00;
    localparam logic [7:0] OFS_PIN_POL = 8'h04;
    localparam logic [7:0] OFS_PIN_SEL = 8'h08;
    localparam logic [7:0] OFS_RAIL_CFG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_START = 8'h24;
    localparam logic [7:0] OFS_ACTIVE_LVL = 8'h28;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        RDSEQ_OFF,
        RDSEQ_ON,
        RDSEQ_WAIT,
        RDSEQ_RAMP
    } rdseq_state_e;

    // per-rail configuration word: on deps[7:0], stay deps[15:8], mode bit 16
    typedef struct packed {
        logic shut_soft;
        logic [7:0] stay_dep;
        logic [7:0] on_dep;
    } rdseq_rail_cfg_s;

    typedef struct packed {
        logic [NUM_RAILS-1:0] running;
        logic [NUM_RAILS-1:0] ramping;
    } rdseq_status_s;
endpackage

// file: core/rdseq_cfg_mem.sv
module rdseq_cfg_mem
    import rdseq_pkg::*;
#(
    parameter int DEPTH = NUM_RAILS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [31:0] rd_data,
    output rdseq_rail_cfg_s cfg_all [DEPTH]
);
    logic [31:0] mem_r [DEPTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= RESET_WORD;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= RESET_WORD;
        end else begin
            rd_data <= mem_r[rd_idx];
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            cfg_all[i] = rdseq_rail_cfg_s'(mem_r[i][16:0]);
        end
    end
endmodule

// file: core/rdseq_top.sv
module rdseq_top
    import rdseq_pkg::*;
#(
    parameter int DELAY_CYC = SOFT_DELAY_CYC,
    parameter int RAMP_CYC = SOFT_RAMP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_RAILS-1:0] rail_pgood,
    input wire logic [NUM_RAILS-1:0] rail_start,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_RAILS-1:0] rail_enable,
    output logic [NUM_RAILS-1:0] rail_switching,
    output logic [NUM_RAILS-1:0] rail_ramp_down
);
    // dependency source vector: [3:0] rails, [7:4] pins
    logic [NUM_PINS-1:0] pin_dir_r;
    logic [NUM_PINS-1:0] pin_pol_r;
    logic [NUM_PINS-1:0] pin_act_lvl_r;
    logic [NUM_RAILS-1:0] pin_sequence_setup_r [NUM_PINS];
    logic [NUM_RAILS-1:0] start_sw_r;
    rdseq_rail_cfg_s cfg [NUM_RAILS];
    logic [31:0] mem_rd;
    rdseq_state_e st_r [NUM_RAILS];
    logic [31:0] cnt_r [NUM_RAILS];
    logic [7:0] src;
    logic [7:0] src_prev_r;
    logic [7:0] src_fall;
    logic [NUM_PINS-1:0] pin_dir_in;
    logic wr_acc;
    logic rd_mem_sel_r;
    logic [31:0] reg_rd_r;
    logic mem_wr;
    rdseq_status_s status;

    function automatic logic [7:0] legal_deps(input logic [7:0] deps, input int rail);
        logic [7:0] m;
        m = deps;
        m[rail] = 1'b0;
        m[7:4] = m[7:4] & pin_dir_in;
        return m;
    endfunction

    assign pin_dir_in = ~pin_dir_r;
    assign wr_acc = psel && penable && pwrite;
    assign mem_wr = wr_acc && paddr[7:4] == OFS_RAIL_CFG[7:4];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // 1 = output, 0 = input; settings kept apart from rail config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_dir_r <= '0;
            pin_pol_r <= '0;
            pin_act_lvl_r <= '1;
            start_sw_r <= '0;
            for (int i = 0; i < NUM_PINS; i++) begin
                pin_sequence_setup_r[i] <= '0;
            end
        end else if (wr_acc) begin
            unique case (paddr)
                OFS_PIN_DIR: pin_dir_r <= pwdata[NUM_PINS-1:0];
                OFS_PIN_POL: pin_pol_r <= pwdata[NUM_PINS-1:0];
                OFS_ACTIVE_LVL: pin_act_lvl_r <= pwdata[NUM_PINS-1:0];
                OFS_START: start_sw_r <= pwdata[NUM_RAILS-1:0];
                OFS_PIN_SEL: begin
                    for (int i = 0; i < NUM_PINS; i++) begin
                        pin_sequence_setup_r[i] <= pwdata[i*8 +: NUM_RAILS];
                    end
                end
                default: ;
            endcase
        end
    end

    rdseq_cfg_mem #(.DEPTH(NUM_RAILS)) u_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_wr),
        .wr_idx(paddr[3:2]),
        .wr_data(pwdata),
        .rd_idx(paddr[3:2]),
        .rd_data(mem_rd),
        .cfg_all(cfg)
    );

    always_comb begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            status.running[r] = st_r[r] == RDSEQ_ON;
            status.ramping[r] = st_r[r] == RDSEQ_RAMP;
        end
    end

    // read data registered one setup cycle ahead; zero-wait apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_rd_r <= '0;
            rd_mem_sel_r <= 1'b0;
        end else if (psel && !penable) begin
            rd_mem_sel_r <= paddr[7:4] == OFS_RAIL_CFG[7:4];
            unique case (paddr)
                OFS_PIN_DIR: reg_rd_r <= 32'(pin_dir_r);
                OFS_PIN_POL: reg_rd_r <= 32'(pin_pol_r);
                OFS_ACTIVE_LVL: reg_rd_r <= 32'(pin_act_lvl_r);
                OFS_START: reg_rd_r <= 32'(start_sw_r);
                OFS_STATUS: reg_rd_r <= 32'(status);
                OFS_PIN_SEL: begin
                    reg_rd_r <= '0;
                    for (int i = 0; i < NUM_PINS; i++) begin
                        reg_rd_r[i*8 +: NUM_RAILS] <= pin_sequence_setup_r[i];
                    end
                end
                default: reg_rd_r <= '0;
            endcase
        end
    end

    assign prdata = rd_mem_sel_r ? mem_rd : reg_rd_r;

    // power-good AND per output pin, with polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                logic good;
                good = ((rail_pgood & pin_sequence_setup_r[i]) == pin_sequence_setup_r[i])
                    && (pin_sequence_setup_r[i] != '0);
                pin_out[i] <= pin_dir_r[i] & (good ^ pin_pol_r[i]);
                pin_oe[i] <= pin_dir_r[i];
            end
        end
    end

    // sources normalised to active-high stay-on level
    assign src = {pin_in ~^ pin_act_lvl_r, rail_pgood};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_r <= '0;
        end else begin
            src_prev_r <= src;
        end
    end

    assign src_fall = src_prev_r & ~src;

    // per-rail controller; on and stay sets independent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                st_r[r] <= RDSEQ_OFF;
                cnt_r[r] <= '0;
            end
        end else begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                logic [7:0] on_m;
                logic [7:0] stay_m;
                on_m = legal_deps(cfg[r].on_dep, r);
                stay_m = legal_deps(cfg[r].stay_dep, r);
                unique case (st_r[r])
                    RDSEQ_OFF: begin
                        // empty set satisfies trivially
                        if ((rail_start[r] | start_sw_r[r]) && (src & on_m) == on_m) begin
                            st_r[r] <= RDSEQ_ON;
                        end
                    end
                    RDSEQ_ON: begin
                        // on deps not read here
                        if ((src_fall & stay_m) != '0) begin
                            if (cfg[r].shut_soft) begin
                                st_r[r] <= RDSEQ_WAIT;
                                cnt_r[r] <= 32'(DELAY_CYC);
                            end else begin
                                st_r[r] <= RDSEQ_OFF;
                            end
                        end else if (!(rail_start[r] | start_sw_r[r])) begin
                            st_r[r] <= RDSEQ_OFF;
                        end
                    end
                    RDSEQ_WAIT: begin
                        if (cnt_r[r] <= 32'd1) begin
                            st_r[r] <= RDSEQ_RAMP;
                            cnt_r[r] <= 32'(RAMP_CYC);
                        end else begin
                            cnt_r[r] <= cnt_r[r] - 32'd1;
                        end
                    end
                    RDSEQ_RAMP: begin
                        // ramp end stands for minimum pulse reached
                        if (cnt_r[r] <= 32'd1) begin
                            st_r[r] <= RDSEQ_OFF;
                            cnt_r[r] <= '0;
                        end else begin
                            cnt_r[r] <= cnt_r[r] - 32'd1;
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            rail_enable[r] = st_r[r] != RDSEQ_OFF;
            rail_switching[r] = st_r[r] != RDSEQ_OFF;
            rail_ramp_down[r] = st_r[r] == RDSEQ_RAMP;
        end
    end

    chk_imm_off_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[0] == RDSEQ_ON && (src_fall & legal_deps(cfg[0].stay_dep, 0)) != '0
         && !cfg[0].shut_soft) |=> !rail_switching[0])
        else $error("immediate-off rail still switching");
    // soft-off watched on rail 3, the rail that is set up for a soft shutdown
    chk_soft_waits: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[3] == RDSEQ_ON && (src_fall & legal_deps(cfg[3].stay_dep, 3)) != '0
         && cfg[3].shut_soft) |=> st_r[3] == RDSEQ_WAIT && rail_switching[3])
        else $error("soft-off did not enter delay");
    chk_out_and_pg: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_dir_r[0] && !pin_pol_r[0] && !$changed(pin_dir_r[0])
         && pin_sequence_setup_r[0] != '0 && !$changed(pin_sequence_setup_r[0])
         && (rail_pgood & pin_sequence_setup_r[0]) != pin_sequence_setup_r[0])
        |=> !pin_out[0])
        else $error("sequencing output high with a rail not good");
    chk_out_drops: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_out[0] && pin_dir_r[0] && !pin_pol_r[0]
         && (rail_pgood & pin_sequence_setup_r[0]) != pin_sequence_setup_r[0])
        |=> !pin_out[0])
        else $error("sequencing output held after a rail failed");
    chk_pol_inverts: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_dir_r[1] && pin_pol_r[1] && pin_sequence_setup_r[1] != '0
         && (rail_pgood & pin_sequence_setup_r[1]) == pin_sequence_setup_r[1])
        |=> pin_oe[1] && !pin_out[1])
        else $error("inverted output not at its active level");
    chk_input_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_dir_r[2] |=> !pin_oe[2] && !pin_out[2])
        else $error("input pin driven");
    // own power-good dips on a quick restart; that dip must never stop the rail
    chk_no_self_dep: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[1] == RDSEQ_ON && (rail_start[1] | start_sw_r[1])
         && (src_fall & cfg[1].stay_dep & 8'hfd) == '0) |=> st_r[1] == RDSEQ_ON)
        else $error("rail dropped by its own power-good");
    chk_held_low_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[2] == RDSEQ_ON && src_fall == '0 && (rail_start[2] | start_sw_r[2]))
        |=> st_r[2] == RDSEQ_ON)
        else $error("rail dropped without a dependency edge");
    chk_start_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[3] == RDSEQ_OFF && (src & legal_deps(cfg[3].on_dep, 3))
         != legal_deps(cfg[3].on_dep, 3)) |=> st_r[3] == RDSEQ_OFF)
        else $error("rail started with turn-on dependency unmet");
    chk_stay_pin_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[0] == RDSEQ_ON && src_fall[6] && cfg[0].stay_dep[6] && !pin_dir_r[2])
        |=> st_r[0] != RDSEQ_ON)
        else $error("input pin loss did not stop the rail");
    chk_wait_to_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[3] == RDSEQ_WAIT && cnt_r[3] == 32'd1) |=> rail_ramp_down[3] && rail_enable[3])
        else $error("delay did not hand over to the ramp");
    chk_ramp_then_off: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[3] == RDSEQ_RAMP && cnt_r[3] == 32'd1) |=> !rail_enable[3])
        else $error("power stage not released after ramp");

    cov_soft_off: cover property (@(posedge pclk) disable iff (!presetn)
        st_r[3] == RDSEQ_RAMP ##1 st_r[3] == RDSEQ_OFF);
    cov_self_edge: cover property (@(posedge pclk) disable iff (!presetn)
        st_r[1] == RDSEQ_ON && src_fall[1] && cfg[1].stay_dep[1]);
    cov_pin_stay_loss: cover property (@(posedge pclk) disable iff (!presetn)
        st_r[0] == RDSEQ_ON && src_fall[6]);
    cov_imm_off: cover property (@(posedge pclk) disable iff (!presetn)
        st_r[1] == RDSEQ_ON ##1 st_r[1] == RDSEQ_OFF);
    cov_pin_out: cover property (@(posedge pclk) disable iff (!presetn)
        pin_oe[0] && pin_out[0]);
endmodule

// file: verification/rdseq_board.sv
module rdseq_board
    import rdseq_pkg::*;
(
    input wire logic pclk,
    input wire logic [NUM_RAILS-1:0] rail_enable,
    input wire logic [NUM_PINS-1:0] ext_lvl,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_RAILS-1:0] rail_pgood,
    output logic [NUM_PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_RAILS-1:0] rise_q = '0;
    logic [NUM_RAILS-1:0] good_q = '0;
    // a rail needs two cycles to reach regulation and drops out just as slowly
    always @(posedge pclk) begin
        rise_q <= rail_enable;
        good_q <= rise_q;
    end
    assign rail_pgood = good_q;
    // our own drive wins on the wire, otherwise the board level shows
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: verification/rdseq_top_tb.sv
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rdseq_top_tb;
    import rdseq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 5;
    localparam int RMP = 10;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, q;
    logic pready, pslverr;
    logic [3:0] start = '0;
    logic [3:0] ext = '0;
    logic [3:0] pgood, pin_in, pin_out, pin_oe, ren, rsw, rramp;
    logic [31:0] dir_m = '0, pol_m = '0, sel_m = '0, act_m = 32'hf, sw_m = '0;
    logic [16:0] cfg_m [4] = '{default: '0};
    logic [3:0] exp_out = '0;
    logic [3:0] exp_oe = '0;
    logic [7:0] prv = '0;
    int st [4] = '{default: 0};
    int cnt [4];
    int miscompares = 0;
    int checks_done = 0;

    initial forever #5 pclk = ~pclk;

    rdseq_top #(.DELAY_CYC(DLY), .RAMP_CYC(RMP)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rail_pgood(pgood),
        .rail_start(start), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .rail_enable(ren), .rail_switching(rsw), .rail_ramp_down(rramp));

    rdseq_board board (.pclk(pclk), .rail_enable(ren), .ext_lvl(ext), .pin_out(pin_out),
        .pin_oe(pin_oe), .rail_pgood(pgood), .pin_in(pin_in));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        logic [3:0] run, rmp;
        for (int r = 0; r < 4; r++) begin
            run[r] = (st[r] == 1);
            rmp[r] = (st[r] == 2 && cnt[r] <= RMP);
        end
        case (a)
            OFS_PIN_DIR: return dir_m;
            OFS_PIN_POL: return pol_m;
            OFS_PIN_SEL: return sel_m;
            OFS_STATUS: return {24'h0, run, rmp};
            OFS_START: return sw_m;
            OFS_ACTIVE_LVL: return act_m;
            default: return (a >= OFS_RAIL_CFG && a < OFS_STATUS) ? {15'h0, cfg_m[a[3:2]]} : '0;
        endcase
    endfunction

    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            report_and_stop();
        end
        q = prdata;
        if (w) begin
            case (a)
                OFS_PIN_DIR: dir_m <= d & 32'hf;
                OFS_PIN_POL: pol_m <= d & 32'hf;
                OFS_PIN_SEL: sel_m <= d & 32'h0f0f_0f0f;
                OFS_START: sw_m <= d & 32'hf;
                OFS_ACTIVE_LVL: act_m <= d & 32'hf;
                default: if (a >= OFS_RAIL_CFG && a < OFS_STATUS) cfg_m[a[3:2]] <= d[16:0];
            endcase
        end
        psel <= 0;
        penable <= 0;
        // one idle edge so a following call never re-drives psel in the same step
        @(posedge pclk);
    endtask

    task automatic rd_all();
        for (int a = 0; a < 48; a += 4) begin
            apb(0, 8'(a), '0);
            `CHK("register", exp_rd(8'(a)), q)
        end
    endtask

    always @(posedge pclk or negedge presetn) begin : model
        logic [7:0] s, m;
        logic [3:0] a;
        logic go;
        if (!presetn) begin
            st = '{default: 0};
            prv = '0;
            exp_out = '0;
            exp_oe = '0;
        end else begin
            s = {~(pin_in ^ act_m[3:0]) & ~dir_m[3:0], pgood};
            for (int r = 0; r < 4; r++) begin
                m = ~(8'h1 << r) & ~{dir_m[3:0], 4'h0};
                go = start[r] | sw_m[r];
                if (st[r] == 0) begin
                    if (go && (cfg_m[r][7:0] & m & ~s) == 0) begin
                        st[r] = 1;
                    end
                end else if (st[r] == 1) begin
                    if (|(cfg_m[r][15:8] & m & prv & ~s)) begin
                        st[r] = cfg_m[r][16] ? 2 : 0;
                        cnt[r] = DLY + RMP;
                    end else if (!go) begin
                        st[r] = 0;
                    end
                end else begin
                    // delay then ramp; start is not looked at until the stage is off
                    cnt[r]--;
                    if (cnt[r] == 0) st[r] = 0;
                end
            end
            prv = s;
            for (int i = 0; i < 4; i++) begin
                a = sel_m[8*i +: 4];
                exp_out[i] = dir_m[i] & (((a != 0) && (a & pgood) == a) ^ pol_m[i]);
            end
            exp_oe = dir_m[3:0];
        end
    end

    // compared mid-cycle, once design and model have both settled
    always @(negedge pclk) begin
        if (presetn) begin
            `CHK("pin_out", exp_out, pin_out)
            `CHK("pin_oe", exp_oe, pin_oe)
            for (int r = 0; r < 4; r++) begin
                `CHK("enable", 1'(st[r] != 0), ren[r])
                `CHK("switching", 1'(st[r] != 0), rsw[r])
                if (st[r] == 2 && cnt[r] <= RMP)
                    `CHK("ramp", 1'b1, rramp[r])
                else
                    `CHK("ramp", 1'b0, rramp[r])
            end
        end
    end

    initial begin
        q = $urandom(32'h01e52248);
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd_all();
        apb(1, OFS_PIN_DIR, 32'hffff_fff3);
        apb(1, OFS_PIN_POL, 32'h6);
        apb(1, OFS_PIN_SEL, 32'h0f02_0106);
        apb(1, OFS_ACTIVE_LVL, 32'h4);
        apb(1, OFS_RAIL_CFG, 32'h0000_4000);
        // rail 1 also names itself as a stay-on source, which must be ignored
        apb(1, OFS_RAIL_CFG + 8'h4, 32'h0000_0303);
        apb(1, OFS_RAIL_CFG + 8'h8, 32'h0000_0292);
        apb(1, OFS_RAIL_CFG + 8'hc, 32'h0001_4404);
        apb(1, OFS_STATUS, 32'hff);
        apb(1, 8'h2c, 32'hff);
        rd_all();
        for (int k = 0; k < 80; k++) begin
            start <= 4'($urandom_range(15)) | ($urandom_range(1) ? 4'hf : 4'h0);
            ext <= 4'($urandom);
            repeat ($urandom_range(20, 1)) @(posedge pclk);
        end
        start <= '0;
        ext <= 4'h4;
        apb(1, OFS_START, 32'hf);
        repeat (30) @(posedge pclk);
        apb(0, OFS_STATUS, '0);
        `CHK("status", exp_rd(OFS_STATUS), q)
        ext <= 4'h0;
        repeat (40) @(posedge pclk);
        apb(0, OFS_STATUS, '0);
        `CHK("status", exp_rd(OFS_STATUS), q)
        report_and_stop();
    end
endmodule
